//--- verilog/gam_alert_output.sv
// Purpose: general output pin mux, low-charge flags, charge-change pulses
//          and battery presence detection with a small register file
// Assumes: byte-wide register port; charge percentage 0..100 from the gauge
// Notes: polarity bit 1 means active high on the output pin
`timescale 1ns/1ps
`include "gam_regs.svh"

// Overview of operation
// R1 - polarity bit sets output active level
// R2 - select bit picks low indicator or pulses
// R3 - indicator mode output follows first flag
// R4 - first flag set below, cleared above level
// R5 - final flag sets below, clears above clear
// R6 - each qualifying event gives 1 ms pulse; code merges same-cycle events, queues one retrigger, drops gap fires
// R7 - pulse at step points and 100%/0%
// R8 - pulse on charge or discharge entry; code gives it only while the step register is nonzero
// R9 - pulse on removal seen at presence pin
// R10 - host pulls pin low for insertion
// R11 - host raises pin high for removal
// R12 - pin ignored when disabled; subcommands instead
// R13 - normal gauging needs insertion and init done
// R14 - subcommand written low byte then high
// R15 - reached at serial write AA, read AB
// R16 - pulse mode rests at inactive level
module gam_alert_output (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    // gauge core
    input wire logic [7:0] chargePercentage,
    input wire logic [1:0] chargeState,
    input wire logic initDone,
    // pins
    input wire logic batteryPresencePin,
    output logic generalOutputPin,
    // status out
    output logic normalMode,
    output logic irq
);

    gam_pkg::gam_state_t st;
    gam_pkg::gam_state_t next_st;
    logic pulseActive; // timer output
    logic [3:0] events; // this cycle's interrupt events
    logic [15:0] cmdCode; // assembled subcommand
    logic socEvent; // step crossing
    logic stateEvent; // charge or discharge entry
    logic pinRise; // removal edge
    logic pinFall; // insertion edge
    logic doInsert;
    logic doRemove;
    logic wrHit;

    // --------------------------------------------------------------
    // step helper
    // --------------------------------------------------------------
    // count of step points at or above x and below full, used for both directions
    function automatic logic [7:0] gam_steps(input logic [7:0] x, input logic [7:0] d);
        logic [7:0] span;
        span = (x > `GAM_SOC_FULL) ? 8'h00 : `GAM_SOC_FULL - x;
        gam_steps = (d == 8'h00) ? 8'h00 : span / d;
    endfunction

    // --------------------------------------------------------------
    // pulse timer
    // --------------------------------------------------------------
    gam_pulse_timer pulseTimer (
        .clock(clock),
        .rst_b(rst_b),
        .fire(st.trig),
        .active(pulseActive)
    );

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    always_comb begin
        next_st = st;
        events = 4'h0;
        wrHit = 1'b0;
        cmdCode = {regWrData, st.cmdLo};
        pinRise = st.cfgPresEn && !st.pinPrev && batteryPresencePin;
        pinFall = st.cfgPresEn && st.pinPrev && !batteryPresencePin;
        doInsert = 1'b0;
        doRemove = 1'b0;
        socEvent = 1'b0;
        stateEvent = 1'b0;

        // register writes; map lives behind the serial front end
        // at write address aa and read address ab
        if (regWrite) begin // R15
            case (regAddr)
                `GAM_OFS_CMD_LO: begin
                    // low byte is held until the high byte lands
                    next_st.cmdLo = regWrData; // R14
                end
                `GAM_OFS_CMD_HI: begin
                    // high byte completes and runs the subcommand
                    wrHit = 1'b1; // R14
                end
                `GAM_OFS_CONFIG: begin
                    next_st.cfgPol = regWrData[`GAM_CFG_POL];
                    next_st.cfgLowSel = regWrData[`GAM_CFG_LOWSEL];
                    next_st.cfgPresEn = regWrData[`GAM_CFG_PRESEN];
                end
                `GAM_OFS_FIRST_SET: next_st.firstSet = regWrData;
                `GAM_OFS_FINAL_SET: next_st.finalSet = regWrData;
                `GAM_OFS_FINAL_CLR: next_st.finalClr = regWrData;
                `GAM_OFS_STEP: next_st.step = regWrData;
                `GAM_OFS_IRQ_MASK: next_st.irqMask = regWrData[3:0];
                default: begin
                    // other offsets ignore writes here; irq status offset is cleared further down
                end
            endcase
        end

        // presence source: pin when enabled, subcommands otherwise
        if (st.cfgPresEn) begin
            doInsert = pinFall; // R10
            doRemove = pinRise; // R11
        end else if (wrHit) begin
            doInsert = (cmdCode == `GAM_CMD_INSERT); // R12
            doRemove = (cmdCode == `GAM_CMD_REMOVE); // R12
        end
        next_st.pinPrev = batteryPresencePin;
        if (doInsert) begin
            next_st.inserted = 1'b1;
        end else if (doRemove) begin
            next_st.inserted = 1'b0;
        end

        // gauging mode: leave init only with battery and init done
        case (st.mode)
            gam_pkg::GAM_INIT: begin
                if (st.inserted && initDone) begin
                    next_st.mode = gam_pkg::GAM_NORMAL; // R13
                end
            end
            gam_pkg::GAM_NORMAL: begin
                if (!st.inserted) begin
                    next_st.mode = gam_pkg::GAM_INIT; // R13
                end
            end
            default: next_st.mode = gam_pkg::GAM_INIT;
        endcase

        // first low flag, simple set and clear at one level
        if (chargePercentage < st.firstSet) begin
            next_st.firstFlag = 1'b1; // R4
        end else if (chargePercentage > st.firstSet) begin
            next_st.firstFlag = 1'b0; // R4
        end

        // final low flag, hysteresis between two levels
        if (chargePercentage < st.finalSet) begin
            next_st.finalFlag = 1'b1; // R5
        end else if (st.finalFlag && chargePercentage > st.finalClr) begin
            next_st.finalFlag = 1'b0; // R5
        end

        // step crossings, judged by the direction of the change
        if (st.step != 8'h00) begin
            if (chargePercentage > st.socPrev) begin
                // rising: passed above a point, or reached full
                socEvent = (gam_steps(st.socPrev, st.step) >
                            gam_steps(chargePercentage, st.step))
                           || (chargePercentage == `GAM_SOC_FULL); // R7
            end else if (chargePercentage < st.socPrev) begin
                // falling: reached a point, or reached empty
                socEvent = (gam_steps(chargePercentage, st.step) >
                            gam_steps(st.socPrev, st.step))
                           || (chargePercentage == `GAM_SOC_EMPTY); // R7
            end
            // entry to charge or discharge, relax excluded
            stateEvent = (chargeState != st.chgPrev) &&
                         (chargeState == `GAM_CHG_CHARGE ||
                          chargeState == `GAM_CHG_DISCHARGE); // R8
        end
        next_st.socPrev = chargePercentage;
        next_st.chgPrev = chargeState;

        // one trigger covers every pulse source
        next_st.trig = socEvent || stateEvent || (pinRise && st.cfgPresEn); // R6 R9

        // output mux and polarity; pulse mode rests inactive
        next_st.general_output_pin = ~((next_st.cfgLowSel ? next_st.firstFlag : pulseActive)
                          ^ next_st.cfgPol); // R1 R2 R3 R16

        // sticky interrupt status; a new event wins over the clear
        events[`GAM_IRQ_PULSE] = st.trig;
        events[`GAM_IRQ_INSERT] = doInsert;
        events[`GAM_IRQ_REMOVE] = doRemove;
        events[`GAM_IRQ_FIRST] = next_st.firstFlag != st.firstFlag;
        if (regWrite && regAddr == `GAM_OFS_IRQ_STAT) begin
            next_st.irqStat = st.irqStat & ~regWrData[3:0];
        end
        next_st.irqStat = next_st.irqStat | events;
        next_st.irq = |(next_st.irqStat & next_st.irqMask);

        // read data stand for one cycle only
        next_st.rdData = 8'h00;
        if (regRead) begin
            case (regAddr)
                `GAM_OFS_CMD_LO: next_st.rdData = st.cmdLo;
                `GAM_OFS_CONFIG: next_st.rdData = {5'h00, st.cfgPresEn,
                                                   st.cfgLowSel, st.cfgPol};
                `GAM_OFS_FIRST_SET: next_st.rdData = st.firstSet;
                `GAM_OFS_FINAL_SET: next_st.rdData = st.finalSet;
                `GAM_OFS_FINAL_CLR: next_st.rdData = st.finalClr;
                `GAM_OFS_STEP: next_st.rdData = st.step;
                `GAM_OFS_STATUS: begin
                    next_st.rdData = {3'h0, st.general_output_pin,
                                      st.mode == gam_pkg::GAM_NORMAL,
                                      st.inserted, st.finalFlag, st.firstFlag};
                end
                `GAM_OFS_IRQ_STAT: next_st.rdData = {4'h0, st.irqStat};
                `GAM_OFS_IRQ_MASK: next_st.rdData = {4'h0, st.irqMask};
                default: next_st.rdData = 8'h00; // unmapped reads zero
            endcase
        end
    end

    // --------------------------------------------------------------
    // registers
    // --------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            st <= '0;
            st.cfgPol <= 1'(`GAM_RST_CONFIG >> `GAM_CFG_POL);
            st.cfgLowSel <= 1'(`GAM_RST_CONFIG >> `GAM_CFG_LOWSEL);
            st.cfgPresEn <= 1'(`GAM_RST_CONFIG >> `GAM_CFG_PRESEN);
            st.firstSet <= `GAM_RST_FIRST_SET;
            st.finalSet <= `GAM_RST_FINAL_SET;
            st.finalClr <= `GAM_RST_FINAL_CLR;
            st.step <= `GAM_RST_STEP;
            st.pinPrev <= 1'b1; // pulled-up pin idles high
            st.mode <= gam_pkg::GAM_INIT;
            st.general_output_pin <= 1'b0; // pulse mode idles low under active-high default R16
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from flops
    assign regRdData = st.rdData;
    assign generalOutputPin = st.general_output_pin;
    assign normalMode = (st.mode == gam_pkg::GAM_NORMAL);
    assign irq = st.irq;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    property p_indicator;
        @(posedge clock) disable iff (!rst_b)
        st.cfgLowSel |-> st.general_output_pin == ~(st.firstFlag ^ st.cfgPol);
    endproperty
    a_indicator: assert property (p_indicator) else $error("indicator level wrong"); // R3

    property p_pulse_level;
        @(posedge clock) disable iff (!rst_b)
        !st.cfgLowSel && $past(rst_b) |-> st.general_output_pin == ~($past(pulseActive) ^ st.cfgPol);
    endproperty
    a_pulse_level: assert property (p_pulse_level) else $error("pulse level wrong"); // R16

    property p_first_set;
        @(posedge clock) disable iff (!rst_b)
        chargePercentage < st.firstSet |=> st.firstFlag
            && (st.irqStat[`GAM_IRQ_FIRST] || $past(st.firstFlag));
    endproperty
    a_first_set: assert property (p_first_set) else $error("first flag not set"); // R4

    property p_first_clr;
        @(posedge clock) disable iff (!rst_b)
        chargePercentage > st.firstSet && !regWrite |=> !st.firstFlag;
    endproperty
    a_first_clr: assert property (p_first_clr) else $error("first flag not cleared"); // R4

    property p_final_hold;
        @(posedge clock) disable iff (!rst_b)
        !st.finalFlag && chargePercentage >= st.finalSet && !regWrite |=> !st.finalFlag;
    endproperty
    a_final_hold: assert property (p_final_hold) else $error("final flag set early"); // R5

    property p_state_entry;
        @(posedge clock) disable iff (!rst_b)
        st.step != 8'h00 && chargeState == `GAM_CHG_CHARGE
            && st.chgPrev == `GAM_CHG_RELAX |=> st.trig ##1 pulseActive || $past(pulseActive);
    endproperty
    a_state_entry: assert property (p_state_entry) else $error("no pulse on entry"); // R8

    property p_full;
        @(posedge clock) disable iff (!rst_b)
        st.step != 8'h00 && chargePercentage == `GAM_SOC_FULL
            && st.socPrev < `GAM_SOC_FULL |=> st.trig;
    endproperty
    a_full: assert property (p_full) else $error("no pulse at full"); // R7

    property p_removal;
        @(posedge clock) disable iff (!rst_b)
        st.cfgPresEn && !st.pinPrev && batteryPresencePin |=> st.trig && !st.inserted;
    endproperty
    a_removal: assert property (p_removal) else $error("removal missed"); // R9

    property p_pin_ignored;
        @(posedge clock) disable iff (!rst_b)
        !st.cfgPresEn && !regWrite |=> $stable(st.inserted);
    endproperty
    a_pin_ignored: assert property (p_pin_ignored) else $error("pin not ignored"); // R12

    property p_normal;
        @(posedge clock) disable iff (!rst_b)
        $rose(normalMode) |-> $past(st.inserted) && $past(initDone);
    endproperty
    a_normal: assert property (p_normal) else $error("normal without battery"); // R13

    c_normal: cover property (@(posedge clock) disable iff (!rst_b) $rose(normalMode));
    c_pulse: cover property (@(posedge clock) disable iff (!rst_b)
        !st.cfgLowSel && $rose(pulseActive));
    c_indicator: cover property (@(posedge clock) disable iff (!rst_b)
        st.cfgLowSel && $changed(st.general_output_pin));
    c_removal: cover property (@(posedge clock) disable iff (!rst_b)
        st.cfgPresEn && $fell(st.inserted));

endmodule

//--- shared/gam_regs.svh
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: byte-wide register port, 200 MHz clock
// Notes: definitions only
`ifndef GAM_REGS_SVH
`define GAM_REGS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define GAM_OFS_CMD_LO 8'h00
`define GAM_OFS_CMD_HI 8'h01
`define GAM_OFS_CONFIG 8'h10
`define GAM_OFS_FIRST_SET 8'h11
`define GAM_OFS_FINAL_SET 8'h12
`define GAM_OFS_FINAL_CLR 8'h13
`define GAM_OFS_STEP 8'h14
`define GAM_OFS_STATUS 8'h18
`define GAM_OFS_IRQ_STAT 8'h19
`define GAM_OFS_IRQ_MASK 8'h1a

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define GAM_CFG_POL 0
`define GAM_CFG_LOWSEL 1
`define GAM_CFG_PRESEN 2
`define GAM_ST_FIRST 0
`define GAM_ST_FINAL 1
`define GAM_ST_INSERTED 2
`define GAM_ST_NORMAL 3
`define GAM_ST_PIN 4
`define GAM_IRQ_PULSE 0
`define GAM_IRQ_INSERT 1
`define GAM_IRQ_REMOVE 2
`define GAM_IRQ_FIRST 3

// ----------------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------------
`define GAM_RST_CONFIG 3'h5
`define GAM_RST_FIRST_SET 8'h0a
`define GAM_RST_FINAL_SET 8'h02
`define GAM_RST_FINAL_CLR 8'h05
`define GAM_RST_STEP 8'h01
`define GAM_CMD_INSERT 16'h000c
`define GAM_CMD_REMOVE 16'h000d
`define GAM_I2C_WR_ADDR 8'haa
`define GAM_I2C_RD_ADDR 8'hab
`define GAM_CHG_RELAX 2'h0
`define GAM_CHG_CHARGE 2'h1
`define GAM_CHG_DISCHARGE 2'h2
`define GAM_SOC_FULL 8'h64
`define GAM_SOC_EMPTY 8'h00

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define GAM_CLK_MHZ 200
`define GAM_PULSE_MS 1
`define GAM_TICK_CYCLES (`GAM_CLK_MHZ)
`define GAM_PULSE_US (`GAM_PULSE_MS * 1000)

`endif

//--- shared/gam_pkg.sv
// Purpose: types shared by the alert output block
// Assumes: constants live in gam_regs.svh
// Notes: state structs of both modules
package gam_pkg;

    // gauging mode
    typedef enum logic {GAM_INIT, GAM_NORMAL} gam_mode_t;

    // pulse timer phases
    typedef enum logic [1:0] {GAM_IDLE, GAM_ACTIVE, GAM_GAP} gam_tstate_t;

    // pulse timer state
    typedef struct packed {
        gam_tstate_t state;
        logic [7:0] tickCnt;
        logic [9:0] usCnt;
        logic pending;
        logic active;
    } gam_timer_t;

    // main block state
    typedef struct packed {
        logic cfgPol;
        logic cfgLowSel;
        logic cfgPresEn;
        logic [7:0] firstSet;
        logic [7:0] finalSet;
        logic [7:0] finalClr;
        logic [7:0] step;
        logic [7:0] cmdLo;
        logic [3:0] irqStat;
        logic [3:0] irqMask;
        logic [7:0] socPrev;
        logic [1:0] chgPrev;
        logic pinPrev;
        logic firstFlag;
        logic finalFlag;
        logic inserted;
        gam_mode_t mode;
        logic trig;
        logic general_output_pin;
        logic irq;
        logic [7:0] rdData;
    } gam_state_t;

endpackage

//--- verilog/gam_pulse_timer.sv
// Purpose: one-millisecond active pulse generator with one queued retrigger
// Assumes: fire is a one-cycle pulse
// Notes: a fire during a pulse is held and replayed after a 1 us gap
`timescale 1ns/1ps
`include "gam_regs.svh"

module gam_pulse_timer (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // request and pulse
    input wire logic fire,
    output logic active
);

    gam_pkg::gam_timer_t st;
    gam_pkg::gam_timer_t next_st;
    logic tickWrap;
    logic lastUs;

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    always_comb begin
        next_st = st;
        tickWrap = (st.tickCnt == 8'(`GAM_TICK_CYCLES - 1));
        lastUs = (st.usCnt == 10'(`GAM_PULSE_US - 1));
        // divider runs only while a pulse or gap is timed
        if (st.state != gam_pkg::GAM_IDLE) begin
            next_st.tickCnt = tickWrap ? 8'h00 : st.tickCnt + 8'h01;
        end
        case (st.state)
            gam_pkg::GAM_IDLE: begin
                // start a fresh pulse
                if (fire) begin
                    next_st.state = gam_pkg::GAM_ACTIVE;
                    next_st.tickCnt = 8'h00;
                    next_st.usCnt = 10'h000;
                end
            end
            gam_pkg::GAM_ACTIVE: begin
                // remember a fire that lands mid pulse
                if (fire) begin
                    next_st.pending = 1'b1;
                end
                if (tickWrap) begin
                    next_st.usCnt = st.usCnt + 10'h001;
                    if (lastUs) begin
                        next_st.state = (st.pending || fire) ? gam_pkg::GAM_GAP
                                                             : gam_pkg::GAM_IDLE;
                    end
                end
            end
            gam_pkg::GAM_GAP: begin
                // one inactive microsecond keeps pulses apart
                next_st.pending = 1'b0;
                if (tickWrap) begin
                    next_st.state = gam_pkg::GAM_ACTIVE;
                    next_st.usCnt = 10'h000;
                end
            end
            default: begin
                next_st.state = gam_pkg::GAM_IDLE;
            end
        endcase
        next_st.active = (next_st.state == gam_pkg::GAM_ACTIVE);
    end

    // --------------------------------------------------------------
    // registers
    // --------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign active = st.active;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    property p_width;
        @(posedge clock) disable iff (!rst_b)
        $fell(st.active) |-> $past(st.usCnt) == 10'(`GAM_PULSE_US - 1)
            && $past(st.tickCnt) == 8'(`GAM_TICK_CYCLES - 1);
    endproperty
    a_width: assert property (p_width) else $error("pulse width not 1 ms"); // R6

    property p_start;
        @(posedge clock) disable iff (!rst_b)
        fire && st.state == gam_pkg::GAM_IDLE |=> st.active;
    endproperty
    a_start: assert property (p_start) else $error("pulse did not start"); // R6

endmodule

//--- tb/gam_host_model.sv
// Purpose: host side of the battery presence pin
// Assumes: weak pullup on the pin, pack pulls it low
// Notes: present high means a pack sits on the pin
`timescale 1ns/1ps
module gam_host_model (
    // pack control
    input wire logic present,
    // pin
    output logic batteryPresencePin
);
    // pack pulldown wins, pullup raises the pin when pulled out
    assign batteryPresencePin = present ? 1'b0 : 1'b1;
endmodule

//--- tb/tb_top.sv
// Purpose: self-checking bench for the alert output block
// Assumes: 200 MHz clock, sync active-low reset
// Notes: pulses are checked at start and held, never to the end
`timescale 1ns/1ps
`include "gam_regs.svh"
module tb_top;
    // ----------------------------------------
    // signals and bench state
    // ----------------------------------------
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [7:0] regRdData;
    logic [7:0] chargePercentage = 8'h00;
    logic [1:0] chargeState = 2'h0;
    logic initDone = 1'b0;
    logic present = 1'b0;
    logic batteryPresencePin;
    logic generalOutputPin;
    logic normalMode;
    logic irq;
    integer error_cnt = 0;
    integer cmp_count = 0;
    integer cycles = 0;
    integer seed = 32'hee33383c;
    integer f1;
    integer f2;
    integer c;
    integer k;
    integer p;

    always #2.5 clock = ~clock;

    gam_alert_output i_dut (.clock(clock), .rst_b(rst_b), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .chargePercentage(chargePercentage),
        .chargeState(chargeState), .initDone(initDone),
        .batteryPresencePin(batteryPresencePin),
        .generalOutputPin(generalOutputPin), .normalMode(normalMode), .irq(irq));
    gam_host_model i_host (.present(present), .batteryPresencePin(batteryPresencePin));

    // hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            error_cnt = error_cnt + 1;
            end_sim;
        end
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic cyc(input integer n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        regWrite <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge clock);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regRead <= 1'b0;
        #1;
        chk(regRdData & m, e);
    endtask

    // subcommand, low byte first
    task automatic cmd(input logic [15:0] code);
        wr(`GAM_OFS_CMD_LO, code[7:0]);
        wr(`GAM_OFS_CMD_HI, code[15:8]);
    endtask

    task automatic rst;
        @(posedge clock);
        rst_b <= 1'b0;
        chargePercentage <= 8'h00;
        chargeState <= `GAM_CHG_RELAX;
        present <= 1'b0;
        initDone <= 1'b0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
    endtask

    // one pulse-mode event per kind, reset kills the running pulse
    task automatic pulse(input integer kind);
        logic pol;
        logic act;
        pol = (kind != 5);
        act = (kind != 4) && (kind != 6);
        rst;
        wr(`GAM_OFS_CONFIG, kind == 4 ? 8'h01 : (kind == 5 ? 8'h04 : 8'h05));
        if (kind == 6) wr(`GAM_OFS_STEP, 8'h00);
        if (kind == 3 || kind == 4) @(posedge clock) present <= 1'b1;
        cyc(5);
        chk(generalOutputPin, !pol);
        @(posedge clock);
        case (kind)
            1: chargeState <= `GAM_CHG_CHARGE;
            2: chargeState <= `GAM_CHG_DISCHARGE;
            3, 4: present <= 1'b0;
            default: chargePercentage <= 8'h01;
        endcase
        cyc(5);
        chk(generalOutputPin, act == pol);
        cyc(1500);
        chk(generalOutputPin, act == pol);
        if (kind == 4) rd(`GAM_OFS_STATUS, 8'h00, 8'h04);
        if (kind == 3) rd(`GAM_OFS_IRQ_STAT, 8'h04, 8'h04);
    endtask

    task automatic end_sim;
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst;
        rd(`GAM_OFS_CONFIG, 8'h05, 8'hff);
        rd(`GAM_OFS_FIRST_SET, 8'h0a, 8'hff);
        rd(8'hff, 8'h00, 8'hff);
        // indicator mode against the flag model
        wr(`GAM_OFS_CONFIG, 8'h03);
        f1 = 1;
        f2 = 1;
        p = 0;
        for (k = 0; k < 40; k++) begin
            c = $unsigned($random(seed)) % (k[0] ? 101 : 16);
            @(posedge clock);
            chargePercentage <= c[7:0];
            if (c < 10) f1 = 1;
            else if (c > 10) f1 = 0;
            if (c < 2) f2 = 1;
            else if (f2 == 1 && c > 5) f2 = 0;
            cyc(3);
            chk(generalOutputPin, f1[0]);
            rd(`GAM_OFS_STATUS, {6'h00, f2[0], f1[0]}, 8'h03);
            // step of one: every change of charge crosses a point
            rd(`GAM_OFS_IRQ_STAT, {7'h00, c != p}, 8'h01);
            wr(`GAM_OFS_IRQ_STAT, 8'h01);
            p = c;
        end
        wr(`GAM_OFS_CONFIG, 8'h02);
        cyc(3);
        chk(generalOutputPin, !f1[0]);
        // insertion by pin, then by subcommand
        rst;
        @(posedge clock) present <= 1'b1;
        cyc(5);
        chk(normalMode, 1'b0);
        rd(`GAM_OFS_STATUS, 8'h04, 8'h04);
        @(posedge clock) initDone <= 1'b1;
        cyc(4);
        chk(normalMode, 1'b1);
        wr(`GAM_OFS_CONFIG, 8'h01);
        wr(`GAM_OFS_IRQ_MASK, 8'h06);
        wr(`GAM_OFS_IRQ_STAT, 8'h0f);
        cmd(`GAM_CMD_REMOVE);
        cyc(4);
        chk({normalMode, irq}, 2'b01);
        wr(`GAM_OFS_IRQ_STAT, 8'h04);
        cyc(2);
        chk(irq, 1'b0);
        cmd(`GAM_CMD_INSERT);
        cyc(4);
        chk({normalMode, irq}, 2'b11);
        wr(`GAM_OFS_IRQ_MASK, 8'h00);
        cyc(2);
        chk(irq, 1'b0);
        for (k = 0; k < 7; k++) pulse(k);
        end_sim;
    end
endmodule
